//--- core/ptp_tb_pkg.sv
package ptp_tb_pkg;

  // Timebase widths
  localparam int SEC_W = 48;
  localparam int NS_W = 30;
  localparam int LEAP_W = 8;
  localparam int WIN_W = 16;
  localparam int HOLD_W = 32;

  // Clock rate and timing
  localparam int CLK_HZ = 40000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int NS_PER_SEC = 1000000000;
  localparam int PPS_NOM_MS = 1000;
  localparam int PPS_TOL_US = 100;
  localparam int PPS_NOM_CYC = PPS_NOM_MS * (CLK_HZ / 1000);
  localparam int PPS_TOL_CYC = PPS_TOL_US * (CLK_HZ / 1000000);
  localparam int PPS_QUAL_CNT = 3;
  localparam int MSG_MISS_LIMIT = 3;
  localparam int MSG_TIMEOUT_CYC = PPS_NOM_CYC + PPS_NOM_CYC / 2;

  // Epoch conversion: GPS epoch minus PTP epoch in seconds
  localparam logic [SEC_W-1:0] GPS_TO_PTP_SEC = 48'h0000_12D5_3D80;
  localparam logic [SEC_W-1:0] SEC_RESET = 48'h0000_0000_0000;

  // Output frequency check
  localparam longint FOUT_BASE_HZ = 125000000;
  localparam longint FOUT_M_LIMIT = 131072;

  // Operating mode pin codes
  localparam logic [1:0] MODE_MASTER = 2'h0;
  localparam logic [1:0] MODE_SELFTEST = 2'h1;
  localparam logic [1:0] MODE_SELFTEST_DBG = 2'h2;
  localparam logic [1:0] MODE_RESTORE = 2'h3;

  typedef enum logic [1:0] {
    SRC_LOCAL = 2'b00,
    SRC_REF0 = 2'b01,
    SRC_REF1 = 2'b10
  } src_t;

  typedef enum logic [1:0] {
    PPS_IDLE = 2'b00,
    PPS_COUNT = 2'b01,
    PPS_LOCK = 2'b10
  } pps_state_t;

  typedef struct packed {
    logic [SEC_W-1:0] sec;
    logic [NS_W-1:0] ns;
  } ptp_time_t;

  typedef struct packed {
    logic [SEC_W-1:0] gps_sec;
    logic [LEAP_W-1:0] leap_count;
    logic is_tai;
    logic leap_pending;
  } tod_cfg_t;

endpackage : ptp_tb_pkg

//--- core/pps_qualifier.sv
`timescale 1ns/100ps
module pps_qualifier
  import ptp_tb_pkg::*;
(
  input wire logic ref_clk_i, // System clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic pps_rise_i, // One-cycle rising edge of 1PPS
  output logic qualified_o, // 1PPS accepted
  output logic top_of_sec_o // Accepted edge pulse
);
  pps_state_t state;
  pps_state_t next_state;
  logic [31:0] gap;
  logic [31:0] next_gap;
  logic [1:0] good;
  logic [1:0] next_good;
  logic in_win;
  logic late;
  logic lock_q;
  logic next_lock;

  // Spacing window checks around one second
  assign in_win = (gap >= 32'(PPS_NOM_CYC - PPS_TOL_CYC)) && (gap <= 32'(PPS_NOM_CYC + PPS_TOL_CYC));
  assign late = gap > 32'(PPS_NOM_CYC + PPS_TOL_CYC);

  // Next state of qualifier
  always_comb
  begin
    next_state = state;
    next_good = good;
    next_gap = (gap == 32'hFFFF_FFFF) ? gap : gap + 32'h1;
    top_of_sec_o = 1'b0;
    case (state)
      PPS_IDLE:
      begin
        if (pps_rise_i)
        begin
          next_state = PPS_COUNT;
          next_good = 2'h1;
          next_gap = 32'h0;
        end
      end
      PPS_COUNT:
      begin
        if (pps_rise_i)
        begin
          next_gap = 32'h0;
          if (in_win)
          begin
            next_good = good + 2'h1;
            if (good + 2'h1 == 2'(PPS_QUAL_CNT))
              next_state = PPS_LOCK;
          end
          else
            next_good = 2'h1;
        end
        else if (late)
          next_state = PPS_IDLE;
      end
      PPS_LOCK:
      begin
        if (pps_rise_i && in_win)
        begin
          next_gap = 32'h0;
          top_of_sec_o = 1'b1;
        end
        else if (pps_rise_i || late)
          next_state = PPS_IDLE;
      end
      default:
        next_state = PPS_IDLE;
    endcase
    next_lock = (next_state == PPS_LOCK); // Accepted flag straight from a flop
  end

  // Register qualifier state
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state <= PPS_IDLE;
      gap <= 32'h0;
      good <= 2'h0;
      lock_q <= 1'b0;
    end
    else
    begin
      state <= next_state;
      gap <= next_gap;
      good <= next_good;
      lock_q <= next_lock;
    end
  end

  assign qualified_o = lock_q;
endmodule : pps_qualifier

//--- core/ptp_timebase.sv
`timescale 1ns/100ps
module ptp_timebase
  import ptp_tb_pkg::*;
#(
  parameter int NS_STEP = CLK_PERIOD_NS
)
(
  input wire logic ref_clk_i, // 40 MHz system clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic [1:0] operating_mode_pins_i, // Mode straps
  input wire logic [1:0] ref_present_i, // Reference clocks active
  input wire logic [1:0] ref_tick_i, // Reference-derived rate ticks
  input wire logic [1:0] ref_sel_i, // Software reference choice
  input wire logic align_en_i, // Align to external timebase
  input wire logic pps_i, // 1PPS input level
  input wire logic msg_valid_i, // Timing message strobe
  input wire tod_cfg_t tod_i, // Message seconds and leap data
  input wire logic locked_i, // Adequate lock indication
  input wire logic [WIN_W-1:0] hold_window_i, // Holdover window seconds
  input wire logic [31:0] fout_hz_i, // Requested output frequency
  input wire logic sync_tx_i, // Sync egress at MAC
  input wire logic dreq_rx_i, // Delay-Request ingress at MAC
  input wire logic dresp_tx_i, // Delay-Response being built
  output ptp_time_t now_o, // Local time
  output ptp_time_t t1_o, // Sync origin stamp
  output logic t1_valid_o, // Sync stamp pulse
  output ptp_time_t t4_o, // Delay-Request receive stamp
  output logic t4_valid_o, // Receive stamp pulse
  output ptp_time_t dresp_ts_o, // Stamp for Delay-Response field
  output logic dresp_valid_o, // Insert pulse
  output logic ref_fail_alarm_o, // Timebase reference failed
  output logic time_traceable_o, // Sync traceable flag
  output logic pps_ok_o, // 1PPS accepted
  output logic holdover_o, // Running in holdover
  output logic [HOLD_W-1:0] hold_avg_o, // Holdover correction
  output logic fout_ok_o, // Output frequency supported
  output logic [1:0] mode_o, // Latched operating mode
  output logic leap_armed_o // Leap second pending
);
  ptp_time_t tb, next_tb;
  ptp_time_t t1, next_t1, t4, next_t4, dr, next_dr;
  logic t1v, next_t1v, t4v, next_t4v, drv, next_drv;
  logic [1:0] mode, next_mode;
  logic mode_done, next_mode_done;
  logic pps_d, pps_rise, pps_ok, tos;
  logic [31:0] msg_gap, next_msg_gap;
  logic [1:0] miss, next_miss;
  logic fail, next_fail, trace, next_trace;
  logic aligned, next_aligned;
  logic [SEC_W-1:0] pend_sec, next_pend_sec;
  logic pend, next_pend;
  logic leap, next_leap;
  logic [WIN_W-1:0] win_cnt, next_win_cnt;
  logic [HOLD_W-1:0] acc, next_acc, avg, next_avg;
  logic [HOLD_W-1:0] rate_cnt, next_rate_cnt;
  logic hold, next_hold;
  logic fok, next_fok;
  src_t src;
  logic tick;
  logic sec_wrap;
  logic [NS_W-1:0] ns_add;

  pps_qualifier u_pps (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pps_rise_i(pps_rise),
    .qualified_o(pps_ok),
    .top_of_sec_o(tos)
  );

  // Reference selection and rate tick
  always_comb
  begin
    src = SRC_LOCAL;
    if (ref_sel_i == SRC_REF0 && ref_present_i[0])
      src = SRC_REF0;
    else if (ref_sel_i == SRC_REF1 && ref_present_i[1])
      src = SRC_REF1;
    case (src)
      SRC_REF0: tick = ref_tick_i[0];
      SRC_REF1: tick = ref_tick_i[1];
      default: tick = 1'b1;
    endcase
  end

  assign pps_rise = pps_i && !pps_d;
  assign ns_add = NS_W'(NS_STEP);
  assign sec_wrap = (tb.ns + ns_add) >= NS_W'(NS_PER_SEC);

  // Timebase, alignment and epoch load
  always_comb
  begin
    next_tb = tb;
    next_aligned = aligned;
    next_pend_sec = pend_sec;
    next_pend = pend;
    next_leap = leap;
    if (tod_i.leap_pending && msg_valid_i)
      next_leap = 1'b1;
    if (msg_valid_i)
    begin
      // GPS seconds to PTP epoch, plus leap count for TAI
      next_pend_sec = tod_i.gps_sec + GPS_TO_PTP_SEC;
      if (tod_i.is_tai)
        next_pend_sec = tod_i.gps_sec + GPS_TO_PTP_SEC + SEC_W'(tod_i.leap_count);
      next_pend = 1'b1;
    end
    if (tick)
    begin
      if (sec_wrap)
      begin
        next_tb.ns = tb.ns + ns_add - NS_W'(NS_PER_SEC);
        next_tb.sec = tb.sec + 48'h1;
        if (leap)
        begin
          next_tb.sec = tb.sec + 48'h2;
          next_leap = tod_i.leap_pending && msg_valid_i; // A new pending leap wins
        end
      end
      else
        next_tb.ns = tb.ns + ns_add;
    end
    if (align_en_i && tos)
    begin
      next_tb.ns = '0;
      if (pend)
      begin
        next_tb.sec = pend_sec;
        next_pend = msg_valid_i; // A new message wins over the load
        next_aligned = 1'b1;
      end
      else
        next_tb.sec = tb.sec + (tb.ns >= NS_W'(NS_PER_SEC / 2) ? 48'h1 : 48'h0);
    end
  end

  // Timestamp capture from the one timebase
  always_comb
  begin
    next_t1 = t1;
    next_t4 = t4;
    next_dr = dr;
    next_t1v = 1'b0;
    next_t4v = 1'b0;
    next_drv = 1'b0;
    if (sync_tx_i)
    begin
      next_t1 = tb;
      next_t1v = 1'b1;
    end
    if (dreq_rx_i)
    begin
      next_t4 = tb;
      next_t4v = 1'b1;
    end
    if (dresp_tx_i)
    begin
      next_dr = t4;
      next_drv = 1'b1;
    end
  end

  // Timing message watchdog
  always_comb
  begin
    next_msg_gap = msg_gap;
    next_miss = miss;
    next_fail = fail;
    next_trace = trace;
    if (msg_valid_i)
    begin
      next_msg_gap = 32'h0;
      next_miss = 2'h0;
      next_fail = 1'b0;
      next_trace = align_en_i && pps_ok;
    end
    else if (align_en_i && msg_gap >= 32'(MSG_TIMEOUT_CYC))
    begin
      next_msg_gap = 32'h0;
      if (miss + 2'h1 >= 2'(MSG_MISS_LIMIT))
      begin
        next_fail = 1'b1;
        next_trace = 1'b0;
      end
      else
        next_miss = miss + 2'h1;
    end
    else
      next_msg_gap = msg_gap + 32'h1;
    if (!pps_ok)
      next_trace = 1'b0;
    if (!next_aligned)
      next_trace = 1'b0; // Traceable only once aligned
  end

  // Holdover data over back-to-back fixed windows, cleared after each one
  always_comb
  begin
    next_win_cnt = win_cnt;
    next_acc = acc;
    next_avg = avg;
    next_rate_cnt = rate_cnt;
    next_hold = (src == SRC_LOCAL) || !locked_i;
    if (locked_i && src != SRC_LOCAL)
    begin
      if (tick)
        next_rate_cnt = rate_cnt + 32'h1;
      if (tos || (sec_wrap && tick && !align_en_i))
      begin
        next_acc = acc + rate_cnt;
        next_rate_cnt = 32'h0;
        if (win_cnt + 16'h1 >= hold_window_i)
        begin
          next_avg = acc + rate_cnt;
          next_acc = 32'h0;
          next_win_cnt = 16'h0;
        end
        else
          next_win_cnt = win_cnt + 16'h1;
      end
    end
    else
    begin
      next_rate_cnt = 32'h0;
      next_win_cnt = 16'h0;
      next_acc = 32'h0;
    end
  end

  // Output frequency acceptance
  always_comb
  begin
    next_fok = 1'b0;
    if (fout_hz_i != 32'h0)
      next_fok = (FOUT_BASE_HZ / gcd64(FOUT_BASE_HZ, longint'(fout_hz_i))) < FOUT_M_LIMIT;
  end

  // Mode latched once after reset
  always_comb
  begin
    next_mode = mode;
    next_mode_done = 1'b1;
    if (!mode_done)
      next_mode = operating_mode_pins_i;
  end

  function automatic longint gcd64(input longint a, input longint b);
    longint x;
    longint y;
    longint r;
    x = a;
    y = b;
    for (int i = 0; i < 48; i++)
    begin
      if (y != 0)
      begin
        r = x % y;
        x = y;
        y = r;
      end
    end
    return x;
  endfunction : gcd64

  // Register all state
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      tb <= '{sec: SEC_RESET, ns: '0};
      t1 <= '0;
      t4 <= '0;
      dr <= '0;
      t1v <= 1'b0;
      t4v <= 1'b0;
      drv <= 1'b0;
      mode <= MODE_MASTER;
      mode_done <= 1'b0;
      pps_d <= 1'b0;
      msg_gap <= 32'h0;
      miss <= 2'h0;
      fail <= 1'b0;
      trace <= 1'b0;
      aligned <= 1'b0;
      pend_sec <= SEC_RESET;
      pend <= 1'b0;
      leap <= 1'b0;
      win_cnt <= 16'h0;
      acc <= 32'h0;
      avg <= 32'h0;
      rate_cnt <= 32'h0;
      hold <= 1'b1;
      fok <= 1'b0;
    end
    else
    begin
      tb <= next_tb;
      t1 <= next_t1;
      t4 <= next_t4;
      dr <= next_dr;
      t1v <= next_t1v;
      t4v <= next_t4v;
      drv <= next_drv;
      mode <= next_mode;
      mode_done <= next_mode_done;
      pps_d <= pps_i;
      msg_gap <= next_msg_gap;
      miss <= next_miss;
      fail <= next_fail;
      trace <= next_trace;
      aligned <= next_aligned;
      pend_sec <= next_pend_sec;
      pend <= next_pend;
      leap <= next_leap;
      win_cnt <= next_win_cnt;
      acc <= next_acc;
      avg <= next_avg;
      rate_cnt <= next_rate_cnt;
      hold <= next_hold;
      fok <= next_fok;
    end
  end

  assign now_o = tb;
  assign t1_o = t1;
  assign t1_valid_o = t1v;
  assign t4_o = t4;
  assign t4_valid_o = t4v;
  assign dresp_ts_o = dr;
  assign dresp_valid_o = drv;
  assign ref_fail_alarm_o = fail;
  assign time_traceable_o = trace;
  assign pps_ok_o = pps_ok;
  assign holdover_o = hold;
  assign hold_avg_o = avg;
  assign fout_ok_o = fok;
  assign mode_o = mode;
  assign leap_armed_o = leap;
endmodule : ptp_timebase

//--- tb/ptp_timebase_chk.sv
`timescale 1ns/100ps
module ptp_timebase_chk
  import ptp_tb_pkg::*;
(
  input wire logic ref_clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic locked_i, // Lock level
  input wire logic [31:0] fout_hz_i, // Output frequency
  input wire logic sync_tx_i, // Sync event
  input wire logic dreq_rx_i, // Request event
  input wire logic dresp_tx_i, // Response event
  input wire ptp_time_t now_o, // Local time
  input wire ptp_time_t t1_o, // Sync stamp
  input wire logic t1_valid_o, // Sync stamp pulse
  input wire ptp_time_t t4_o, // Request stamp
  input wire logic t4_valid_o, // Request stamp pulse
  input wire ptp_time_t dresp_ts_o, // Response stamp
  input wire logic dresp_valid_o, // Response pulse
  input wire logic ref_fail_alarm_o, // Alarm
  input wire logic time_traceable_o, // Traceable flag
  input wire logic [HOLD_W-1:0] hold_avg_o, // Holdover data
  input wire logic fout_ok_o, // Frequency verdict
  input wire logic [1:0] mode_o // Latched mode
);
  // Single clock domain
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // Stamps follow their events by one cycle
  chk_sync_stamp: assert property (sync_tx_i |=> t1_valid_o && t1_o == $past(now_o))
    else $error("sync stamp wrong");
  chk_sync_cause: assert property (t1_valid_o |-> $past(sync_tx_i))
    else $error("sync stamp without event");
  chk_req_stamp: assert property (dreq_rx_i |=> t4_valid_o && t4_o == $past(now_o))
    else $error("request stamp wrong");
  chk_resp_field: assert property (dresp_tx_i |=> dresp_valid_o && dresp_ts_o == $past(t4_o))
    else $error("response field wrong");
  // Epoch, straps, holdover, frequency, alarm
  chk_epoch_start: assert property ($past(rst_i) |-> now_o == '0)
    else $error("time not at epoch after reset");
  chk_mode_hold: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> $stable(mode_o))
    else $error("mode changed while running");
  chk_hold_frozen: assert property (!locked_i [*3] |=> $stable(hold_avg_o))
    else $error("holdover data moved while unlocked");
  chk_fout_zero: assert property (fout_hz_i == 32'h0000_0000 |=> !fout_ok_o)
    else $error("zero frequency accepted");
  chk_fout_base: assert property (fout_hz_i == 32'h0773_5940 |=> fout_ok_o)
    else $error("base frequency refused");
  chk_alarm_flag: assert property (ref_fail_alarm_o |-> !time_traceable_o)
    else $error("traceable while alarmed");
  // Main scenarios
  cov_sync: cover property (sync_tx_i ##1 t1_valid_o);
  cov_resp: cover property (dresp_valid_o);
  cov_fout: cover property (fout_ok_o);
endmodule : ptp_timebase_chk

bind ptp_timebase ptp_timebase_chk i_chk (.ref_clk_i, .rst_i, .locked_i, .fout_hz_i, .sync_tx_i,
  .dreq_rx_i, .dresp_tx_i, .now_o, .t1_o, .t1_valid_o, .t4_o, .t4_valid_o, .dresp_ts_o,
  .dresp_valid_o, .ref_fail_alarm_o, .time_traceable_o, .hold_avg_o, .fout_ok_o, .mode_o);

//--- tb/ptp_slave_peer.sv
`timescale 1ns/100ps
module ptp_slave_peer
  import ptp_tb_pkg::*;
(
  input wire logic ref_clk_i, // System clock
  input wire logic rst_i, // Reset
  input wire logic go_i, // Start an exchange
  input wire logic [3:0] gap_i, // Turnaround before response
  input wire logic t4_valid_i, // Receive stamp ready
  output logic dreq_o, // Request arrives
  output logic dresp_o, // Response goes out
  output logic busy_o // Exchange in flight
);
  // Request, wait for its stamp, then response after a gap
  initial
  begin
    dreq_o = 1'b0;
    dresp_o = 1'b0;
    busy_o = 1'b0;
    forever
    begin
      @(posedge ref_clk_i);
      if (go_i && !rst_i)
      begin
        busy_o = 1'b1;
        #1 dreq_o = 1'b1;
        @(posedge ref_clk_i);
        #1 dreq_o = 1'b0;
        for (int w = 0; w < 4 && !t4_valid_i; w++) @(posedge ref_clk_i);
        repeat (gap_i + 1) @(posedge ref_clk_i);
        #1 dresp_o = 1'b1;
        @(posedge ref_clk_i);
        #1 dresp_o = 1'b0;
        busy_o = 1'b0;
      end
    end
  end
endmodule : ptp_slave_peer

//--- tb/ptp_timebase_tb_top.sv
`timescale 1ns/100ps
module ptp_timebase_tb_top
  import ptp_tb_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] pins = 2'h0;
  logic [1:0] present = 2'h3;
  logic [1:0] tick = 2'h0;
  logic [1:0] sel = 2'h0;
  logic locked = 1'b0;
  logic [31:0] fout = 32'h0;
  logic sync_tx = 1'b0;
  logic go = 1'b0;
  logic [3:0] gap = 4'h0;
  logic align = 1'b0;
  logic pps = 1'b0;
  logic msgv = 1'b0;
  tod_cfg_t tod = '0;
  logic alarm, trc, ppsok, hold, leapa, hexp;
  logic [HOLD_W-1:0] havg;
  logic dreq, dresp, busy, t1v, t4v, dv, fok;
  logic [1:0] mode;
  ptp_time_t now, t1, t4, dts, e1, ed, last4;
  ptp_time_t q4 [$];
  logic p1 = 1'b0;
  logic p4 = 1'b0;
  logic pd = 1'b0;
  int mismatches = 0;
  int checked = 0;
  logic [1:0] sels [5] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h1};
  logic [1:0] pres [5] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h0};
  logic [31:0] fset [6] = '{32'h0, 32'h1, 32'h3E8, 32'h3BA, 32'h0773_5940, 32'h001F_4000};

  ptp_timebase i_dut (.ref_clk_i, .rst_i, .operating_mode_pins_i(pins), .ref_present_i(present),
    .ref_tick_i(tick), .ref_sel_i(sel), .align_en_i(align), .pps_i(pps), .msg_valid_i(msgv), .tod_i(tod),
    .locked_i(locked), .hold_window_i(16'h000A), .fout_hz_i(fout), .sync_tx_i(sync_tx), .dreq_rx_i(dreq),
    .dresp_tx_i(dresp), .now_o(now), .t1_o(t1), .t1_valid_o(t1v), .t4_o(t4), .t4_valid_o(t4v),
    .dresp_ts_o(dts), .dresp_valid_o(dv), .ref_fail_alarm_o(alarm), .time_traceable_o(trc), .pps_ok_o(ppsok),
    .holdover_o(hold), .hold_avg_o(havg), .fout_ok_o(fok), .mode_o(mode), .leap_armed_o(leapa));
  ptp_slave_peer i_peer (.ref_clk_i, .rst_i, .go_i(go), .gap_i(gap), .t4_valid_i(t4v), .dreq_o(dreq),
    .dresp_o(dresp), .busy_o(busy));

  // 40 MHz clock
  always #12.5 ref_clk_i = ~ref_clk_i;

  task automatic step();
    @(posedge ref_clk_i);
    #1;
  endtask : step

  task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : cmp_val

  task automatic cmp_time(input string what, input ptp_time_t exp, input ptp_time_t got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : cmp_time

  function automatic logic [79:0] tns(input ptp_time_t t);
    return {32'h0, t.sec} * 80'h3B9A_CA00 + {50'h0, t.ns};
  endfunction : tns

  function automatic logic fout_exp(input longint f);
    longint a;
    longint b;
    longint t;
    a = FOUT_BASE_HZ;
    b = f;
    if (f == 0) return 1'b0;
    while (b != 0)
    begin
      t = a % b;
      a = b;
      b = t;
    end
    return (FOUT_BASE_HZ / a) < FOUT_M_LIMIT;
  endfunction : fout_exp

  // Advance over a window against ticks of the chosen source
  task automatic pace(input logic [1:0] s, input logic [1:0] p);
    ptp_time_t t0;
    int cnt;
    cnt = 0;
    sel = s;
    present = p;
    repeat (3) step();
    t0 = now;
    for (int i = 0; i < 23; i++)
    begin
      tick = (i < 20) ? 2'($urandom) : 2'h0;
      if (s == 2'h1 && p[0]) cnt += tick[0];
      else if (s == 2'h2 && p[1]) cnt += tick[1];
      else cnt++;
      step();
    end
    cmp_val("pace_ns", 32'(cnt * CLK_PERIOD_NS), 32'(tns(now) - tns(t0)));
  endtask : pace

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Stamping model, checked every cycle
  always @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      p1 = 1'b0;
      p4 = 1'b0;
      pd = 1'b0;
      q4.delete();
      last4 = '0;
    end
    else
    begin
      cmp_val("t1_valid", {31'h0, p1}, {31'h0, t1v});
      cmp_val("t4_valid", {31'h0, p4}, {31'h0, t4v});
      cmp_val("dresp_valid", {31'h0, pd}, {31'h0, dv});
      if (p1) cmp_time("t1", e1, t1);
      if (p4) cmp_time("t4", q4.pop_front(), t4);
      if (pd) cmp_time("dresp_ts", ed, dts);
      p1 = sync_tx;
      e1 = now;
      p4 = dreq;
      pd = dresp;
      ed = last4;
      if (dreq) q4.push_back(now);
      if (dreq) last4 = now;
    end
  end

  // Main sequence
  initial
  begin
    void'($urandom(81));
    for (int m = 1; m <= 4; m++)
    begin
      pins = 2'(m);
      rst_i = 1'b1;
      repeat (4) step();
      rst_i = 1'b0;
      step();
      cmp_val("epoch_sec", 32'h0, now.sec[31:0]);
      repeat (2) step();
      cmp_val("mode", {30'h0, 2'(m)}, {30'h0, mode});
      pins = ~pins;
      repeat (3) step();
      cmp_val("mode_run", {30'h0, 2'(m)}, {30'h0, mode});
    end
    $display("test mode_straps done");
    for (int c = 0; c < 5; c++) pace(sels[c], pres[c]);
    $display("test pacing done");
    sel = 2'h0;
    for (int i = 0; i < 60; i++)
    begin
      sync_tx = 1'($urandom);
      go = 1'($urandom);
      gap = 4'($urandom);
      locked = (i < 30);
      step();
    end
    sync_tx = 1'b0;
    go = 1'b0;
    for (int w = 0; w < 40 && busy; w++) step();
    cmp_val("peer_idle", 32'h0, {31'h0, busy});
    $display("test stamps done");
    for (int i = 0; i < 10; i++)
    begin
      fout = (i < 6) ? fset[i] : $urandom;
      repeat (2) step();
      cmp_val("fout_ok", {31'h0, fout_exp(fout)}, {31'h0, fok});
    end
    $display("test fout done");
    // Holdover follows lock and the chosen source
    for (int i = 0; i < 12; i++)
    begin
      sel = 2'($urandom);
      present = 2'($urandom);
      locked = 1'($urandom);
      repeat (2) step();
      hexp = !(locked && ((sel == 2'h1 && present[0]) || (sel == 2'h2 && present[1])));
      cmp_val("holdover", {31'h0, hexp}, {31'h0, hold});
      cmp_val("hold_avg", 32'h0, havg);
    end
    $display("test holdover done");
    // Leap flag from a message, single 1PPS edge not accepted
    align = 1'b1;
    tod = '{gps_sec: 48'($urandom), leap_count: 8'($urandom), is_tai: 1'($urandom), leap_pending: 1'b1};
    msgv = 1'b1;
    pps = 1'b1;
    step();
    msgv = 1'b0;
    pps = 1'b0;
    repeat (2) step();
    cmp_val("leap_armed", 32'h1, {31'h0, leapa});
    cmp_val("pps_ok", 32'h0, {31'h0, ppsok});
    cmp_val("traceable", 32'h0, {31'h0, trc});
    cmp_val("alarm", 32'h0, {31'h0, alarm});
    align = 1'b0;
    $display("test message done");
    end_of_test();
  end

  // Cut a hung run short
  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    mismatches++;
    end_of_test();
  end
endmodule : ptp_timebase_tb_top
